// File: design/flash_cmd_map.svh
// constants of the serial flash command port
`ifndef FLASH_CMD_MAP_SVH
`define FLASH_CMD_MAP_SVH
`define CLK_PERIOD_PS 25000
`define CS_TO_BUSY_NS 200
`define CS_TO_BUSY_CYC ((`CS_TO_BUSY_NS * 1000) / `CLK_PERIOD_PS)
`define XFER_STD_US 250
`define XFER_LOW_US 300
`define EPROG_MS 20
`define PROG_MS 14
`define PERASE_MS 8
`define BERASE_MS 12
`define POWERUP_MS 20
`define US_CYC(x) (((x) * 1000000) / `CLK_PERIOD_PS)
`define MS_CYC(x) (((x) * 1000000) / (`CLK_PERIOD_PS / 1000))
`define HDR_BITS 32
`define BUF_BYTES 264
`define OP_BUF1_RD_LEGACY 8'h54
`define OP_BUF2_RD_LEGACY 8'h56
`define OP_STAT_RD_LEGACY 8'h57
`define OP_ARRAY_RD_LEGACY 8'h68
`define OP_PAGE_RD_LEGACY 8'h52
`define OP_BUF1_RD 8'hd4
`define OP_BUF2_RD 8'hd6
`define OP_STAT_RD 8'hd7
`define OP_ARRAY_RD 8'he8
`define OP_PAGE_RD 8'hd2
`define OP_BUF1_WR 8'h84
`define OP_BUF2_WR 8'h87
`define OP_XFER1 8'h53
`define OP_XFER2 8'h55
`define OP_CMP1 8'h60
`define OP_CMP2 8'h61
`define OP_EPROG1 8'h83
`define OP_EPROG2 8'h86
`define OP_PROG1 8'h88
`define OP_PROG2 8'h89
`define OP_PERASE 8'h81
`define OP_BERASE 8'h50
`endif

// File: design/flash_cmd_pkg.sv
// types of the serial flash command port
package flash_cmd_pkg;
    typedef enum logic [2:0] {
        ST_HDR = 3'b000,
        ST_RDBUF = 3'b001,
        ST_WRBUF = 3'b010,
        ST_STAT = 3'b011,
        ST_IGNORE = 3'b100
    } frame_state_type;
endpackage : flash_cmd_pkg

// File: design/busy_timer.sv
// countdown that holds the device busy for a self-timed operation
`timescale 1ns/1ps
module busy_timer
    import flash_cmd_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [29:0] cycles,
    output logic busy
);
    logic [29:0] count_ff;
    logic [29:0] nxt_count;
    assign nxt_count = start ? cycles : ((count_ff != 30'h0) ? count_ff - 30'h1 : 30'h0);
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            count_ff <= 30'h0;
        end else begin
            count_ff <= nxt_count;
        end
    end
    assign busy = (count_ff != 30'h0);
endmodule : busy_timer

// File: design/serial_flash_command_port.sv
// device side of the serial flash command port
//
// Summary of operation
// - a frame is accepted whether the serial clock idles low or high when select falls.
// - every serial input bit is captured on a rising serial clock edge.
// - a page to buffer transfer or compare ends within 250 us (300 us on the low-voltage part).
// - erase and program 20 ms, program 14 ms, page erase 8 ms, block erase 12 ms.
// - ready/busy goes low within 200 ns of select rising on a self-timed command.
// - legacy reads are 68h array, 52h page, 54h/56h buffer and 57h status.
// - spi-mode reads are e8h array, d2h page, d4h/d6h buffer and d7h status.
`timescale 1ns/1ps
`include "flash_cmd_map.svh"
module serial_flash_command_port
    import flash_cmd_pkg::*;
#(
    parameter int unsigned LOW_VOLTAGE = 0,
    parameter logic [29:0] XFER_CYC_STD = 30'(`US_CYC(`XFER_STD_US)),
    parameter logic [29:0] XFER_CYC_LOW = 30'(`US_CYC(`XFER_LOW_US)),
    parameter logic [29:0] EPROG_CYC = 30'(`MS_CYC(`EPROG_MS)),
    parameter logic [29:0] PROG_CYC = 30'(`MS_CYC(`PROG_MS)),
    parameter logic [29:0] PERASE_CYC = 30'(`MS_CYC(`PERASE_MS)),
    parameter logic [29:0] BERASE_CYC = 30'(`MS_CYC(`BERASE_MS))
)(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic selB,
    input wire logic serClk,
    input wire logic serIn,
    output logic serOut,
    output logic serOutEn,
    output logic readyB,
    output logic [7:0] lastOpcode,
    output logic [10:0] page_addr
);
    //------------------------------------------------------------
    // input synchronisers
    //------------------------------------------------------------
    logic [1:0] selSync_ff, clkSync_ff, dinSync_ff;
    logic selPrev_ff, clkPrev_ff;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            selSync_ff <= 2'h3;
            clkSync_ff <= 2'h0;
            dinSync_ff <= 2'h0;
            selPrev_ff <= 1'b1;
            clkPrev_ff <= 1'b0;
        end else begin
            selSync_ff <= {selSync_ff[0], selB};
            clkSync_ff <= {clkSync_ff[0], serClk};
            dinSync_ff <= {dinSync_ff[0], serIn};
            selPrev_ff <= selSync_ff[1];
            clkPrev_ff <= clkSync_ff[1];
        end
    end
    wire selActive = !selSync_ff[1];
    wire selRise = selSync_ff[1] && !selPrev_ff;
    wire selFall = !selSync_ff[1] && selPrev_ff;
    // edges are only counted inside a frame, so either idle level works
    wire clkRise = selActive && !selFall && clkSync_ff[1] && !clkPrev_ff;
    wire clkFall = selActive && !selFall && !clkSync_ff[1] && clkPrev_ff;
    wire dataIn = dinSync_ff[1];
    //------------------------------------------------------------
    // header shift and decode
    //------------------------------------------------------------
    frame_state_type state_ff, nxt_state;
    logic [31:0] hdr_ff;
    logic [5:0] hdrCnt_ff;
    logic [2:0] bitCnt_ff;
    logic [8:0] bufPtr_ff;
    logic bufSel_ff;
    logic [7:0] wrShift_ff, rdShift_ff;
    logic [7:0] buf0_ff [0:`BUF_BYTES-1];
    logic [7:0] buf1_ff [0:`BUF_BYTES-1];
    logic [7:0] pendOp_ff;
    wire [31:0] hdrNext = {hdr_ff[30:0], dataIn};
    wire [7:0] opNext = hdrNext[31:24];
    wire hdrDone = (state_ff == ST_HDR) && clkRise && (hdrCnt_ff == 6'(`HDR_BITS - 1));
    wire opStatus = (hdrCnt_ff == 6'h7 && (hdrNext[7:0] == `OP_STAT_RD
                    || hdrNext[7:0] == `OP_STAT_RD_LEGACY));
    wire opBufRd = (opNext == `OP_BUF1_RD) || (opNext == `OP_BUF2_RD) ||
                   (opNext == `OP_BUF1_RD_LEGACY) || (opNext == `OP_BUF2_RD_LEGACY);
    wire opBufWr = (opNext == `OP_BUF1_WR) || (opNext == `OP_BUF2_WR);
    wire opBuf2 = (opNext == `OP_BUF2_WR) || (opNext == `OP_BUF2_RD) || (opNext == `OP_BUF2_RD_LEGACY);
    // hdrNext[23:20] are the reserved bits the host holds low; they are not decoded
    wire [10:0] hdrPage = hdrNext[19:9];
    wire [8:0] hdrByte = hdrNext[8:0];
    wire bufWrap = (bufPtr_ff == 9'(`BUF_BYTES - 1));
    wire [8:0] ptrNext = bufWrap ? 9'h0 : bufPtr_ff + 9'h1;
    wire [7:0] bufByte = bufSel_ff ? buf1_ff[bufPtr_ff] : buf0_ff[bufPtr_ff];
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_HDR: begin
                if (opStatus && clkRise) begin
                    nxt_state = ST_STAT;
                end else if (hdrDone) begin
                    nxt_state = opBufRd ? ST_RDBUF : (opBufWr ? ST_WRBUF : ST_IGNORE);
                end
            end
            ST_RDBUF, ST_WRBUF, ST_STAT, ST_IGNORE: nxt_state = state_ff;
            default: nxt_state = ST_HDR;
        endcase
        if (!selActive) begin
            nxt_state = ST_HDR;
        end
    end
    //------------------------------------------------------------
    // frame engine
    //------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= ST_HDR;
            hdr_ff <= 32'h0;
            hdrCnt_ff <= 6'h0;
            bitCnt_ff <= 3'h0;
            bufPtr_ff <= 9'h0;
            bufSel_ff <= 1'b0;
            wrShift_ff <= 8'h0;
            pendOp_ff <= 8'h0;
        end else begin
            state_ff <= nxt_state;
            if (!selActive) begin
                hdrCnt_ff <= 6'h0;
                bitCnt_ff <= 3'h0;
            end else if (clkRise) begin
                hdr_ff <= hdrNext;
                if (state_ff == ST_HDR) begin
                    hdrCnt_ff <= hdrCnt_ff + 6'h1;
                end
                if (hdrDone) begin
                    bufPtr_ff <= hdrByte;
                    bufSel_ff <= opBuf2;
                    pendOp_ff <= opNext;
                    bitCnt_ff <= 3'h0;
                end else if (state_ff == ST_WRBUF) begin
                    wrShift_ff <= {wrShift_ff[6:0], dataIn};
                    bitCnt_ff <= bitCnt_ff + 3'h1;
                    if (bitCnt_ff == 3'h7) begin
                        bufPtr_ff <= ptrNext;
                    end
                end
            end else if (clkFall && (state_ff == ST_RDBUF || state_ff == ST_STAT)) begin
                bitCnt_ff <= bitCnt_ff + 3'h1;
                if (bitCnt_ff == 3'h7 && state_ff == ST_RDBUF) begin
                    bufPtr_ff <= ptrNext;
                end
            end
            if (selRise) begin
                pendOp_ff <= 8'h0;
            end
        end
    end
    wire wrCommit = selActive && clkRise && state_ff == ST_WRBUF && bitCnt_ff == 3'h7;
    always_ff @(posedge core_clk) begin
        if (wrCommit && !bufSel_ff) begin
            buf0_ff[bufPtr_ff] <= {wrShift_ff[6:0], dataIn};
        end
        if (wrCommit && bufSel_ff) begin
            buf1_ff[bufPtr_ff] <= {wrShift_ff[6:0], dataIn};
        end
    end
    //------------------------------------------------------------
    // serial output
    //------------------------------------------------------------
    wire busy;
    wire [7:0] statusByte = {!busy, 7'h0};
    wire loadRd = (state_ff == ST_RDBUF || state_ff == ST_STAT) && clkFall && bitCnt_ff == 3'h0;
    wire [7:0] loadVal = (state_ff == ST_STAT) ? statusByte : bufByte;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdShift_ff <= 8'h0;
            serOut <= 1'b0;
            serOutEn <= 1'b0;
        end else begin
            serOutEn <= selActive && (state_ff == ST_RDBUF || state_ff == ST_STAT);
            if (loadRd) begin
                serOut <= loadVal[7];
                rdShift_ff <= {loadVal[6:0], 1'b0};
            end else if (clkFall && (state_ff == ST_RDBUF || state_ff == ST_STAT)) begin
                serOut <= rdShift_ff[7];
                rdShift_ff <= {rdShift_ff[6:0], 1'b0};
            end
        end
    end
    //------------------------------------------------------------
    // self-timed operations
    //------------------------------------------------------------
    logic [29:0] opCycles;
    wire [29:0] xferCyc = (LOW_VOLTAGE != 0) ? XFER_CYC_LOW : XFER_CYC_STD;
    always_comb begin
        case (pendOp_ff)
            `OP_XFER1, `OP_XFER2, `OP_CMP1, `OP_CMP2: opCycles = xferCyc;
            `OP_EPROG1, `OP_EPROG2: opCycles = EPROG_CYC;
            `OP_PROG1, `OP_PROG2: opCycles = PROG_CYC;
            `OP_PERASE: opCycles = PERASE_CYC;
            `OP_BERASE: opCycles = BERASE_CYC;
            default: opCycles = 30'h0;
        endcase
    end
    wire startOp = selRise && (opCycles != 30'h0) && !busy;
    busy_timer u_busy (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .start(startOp),
        .cycles(opCycles),
        .busy(busy)
    );
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            readyB <= 1'b1;
            lastOpcode <= 8'h0;
            page_addr <= 11'h0;
        end else begin
            readyB <= !(busy || startOp);
            if (hdrDone) begin
                lastOpcode <= opNext;
                page_addr <= hdrPage;
            end
        end
    end
endmodule : serial_flash_command_port

// File: tb/spi_host_model.sv
// spi host model that frames commands for the flash command port
`timescale 1ns/1ps
module spi_host_model (
    input wire logic core_clk,
    output logic selB,
    output logic serClk,
    output logic serIn,
    input wire logic serOut,
    input wire logic serOutEn
);
    logic cpol = 1'b0;
    logic sawEn = 1'b0;
    logic [7:0] rxByte;
    event rxDone;
    initial begin
        selB = 1'b1;
        serClk = 1'b0;
        serIn = 1'b1;
    end
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : wait_cyc
    task automatic open_frame();
        wait_cyc(1);
        serClk = cpol;
        wait_cyc(10);
        selB = 1'b0;
        wait_cyc(10);
    endtask : open_frame
    task automatic close_frame();
        wait_cyc(4);
        serClk = cpol;
        wait_cyc(10);
        selB = 1'b1;
        serIn = ~serIn;
        wait_cyc(12);
    endtask : close_frame
    // data set on the fall, sampled at the end of the high phase
    task automatic send_byte(input logic [7:0] tx, input logic cap);
        for (int i = 7; i >= 0; i--) begin
            serClk = 1'b0;
            serIn = tx[i];
            wait_cyc(4);
            serClk = 1'b1;
            wait_cyc(3);
            rxByte[i] = serOut;
            sawEn = sawEn | serOutEn;
            wait_cyc(1);
        end
        if (cap)
            -> rxDone;
    endtask : send_byte
endmodule : spi_host_model

// File: tb/serial_flash_command_port_monitor.sv
// assertions on the ports of the serial flash command port
`timescale 1ns/1ps
`include "flash_cmd_map.svh"
module serial_flash_command_port_monitor
    import flash_cmd_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic selB,
    input wire logic serClk,
    input wire logic serOut,
    input wire logic serOutEn,
    input wire logic readyB,
    input wire logic [7:0] lastOpcode,
    input wire logic [10:0] page_addr
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    wire logic selfTimed = lastOpcode inside {`OP_XFER1, `OP_XFER2, `OP_CMP1, `OP_CMP2, `OP_EPROG1,
        `OP_EPROG2, `OP_PROG1, `OP_PROG2, `OP_PERASE, `OP_BERASE};
    a_busy_cause: assert property ($fell(readyB) |-> selfTimed) else $error("busy without op");
    a_busy_launch: assert property ($rose(selB) && selfTimed && readyB |-> ##[1:8] !readyB)
        else $error("busy late");
    a_busy_sel: assert property ($fell(readyB) |-> selB) else $error("busy while selected");
    a_busy_hold: assert property ($fell(readyB) |=> !readyB [*7]) else $error("busy too short");
    a_out_release: assert property (selB [*6] |-> !serOutEn) else $error("output not released");
    a_out_edge: assert property (serOutEn && $past(serOutEn) && $changed(serOut) |-> !$past(serClk))
        else $error("output moved off fall");
    a_frame_op: assert property ($changed(lastOpcode) |-> !selB) else $error("opcode outside frame");
    a_frame_page: assert property ($changed(page_addr) |-> !selB) else $error("page outside frame");
    c_busy: cover property ($fell(readyB));
    c_read: cover property ($rose(serOutEn));
    c_mode3: cover property ($fell(selB) && serClk);
endmodule : serial_flash_command_port_monitor
bind serial_flash_command_port serial_flash_command_port_monitor i_monitor (.core_clk(core_clk), .rst_b(rst_b),
    .selB(selB), .serClk(serClk), .serOut(serOut), .serOutEn(serOutEn), .readyB(readyB),
    .lastOpcode(lastOpcode), .page_addr(page_addr));

// File: tb/serial_flash_command_port_test.sv
// self-checking bench for the serial flash command port
`timescale 1ns/1ps
`include "flash_cmd_map.svh"
module serial_flash_command_port_test
    import flash_cmd_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic selB, serClk, serIn, serOut, serOutEn, readyB;
    logic [7:0] lastOpcode;
    logic [10:0] pageAddr;
    int mismatches = 0;
    int totalChecks = 0;
    int seed = 73210;
    int cycles = 0;
    logic [15:0] expQ[$];
    logic [7:0] opTab[10] = '{`OP_XFER1, `OP_XFER2, `OP_CMP1, `OP_CMP2, `OP_EPROG1, `OP_EPROG2, `OP_PROG1,
        `OP_PROG2, `OP_PERASE, `OP_BERASE};
    int lenTab[10] = '{250, 250, 250, 250, 600, 600, 420, 420, 240, 360};
    logic [7:0] rdTab[4] = '{`OP_PAGE_RD_LEGACY, `OP_ARRAY_RD_LEGACY, `OP_PAGE_RD, `OP_ARRAY_RD};
    serial_flash_command_port #(.XFER_CYC_STD(30'd250), .EPROG_CYC(30'd600), .PROG_CYC(30'd420),
        .PERASE_CYC(30'd240), .BERASE_CYC(30'd360)) i_dut (.core_clk(core_clk), .rst_b(rst_b), .selB(selB),
        .serClk(serClk), .serIn(serIn), .serOut(serOut), .serOutEn(serOutEn), .readyB(readyB),
        .lastOpcode(lastOpcode), .page_addr(pageAddr));
    spi_host_model host (.core_clk(core_clk), .selB(selB), .serClk(serClk), .serIn(serIn), .serOut(serOut),
        .serOutEn(serOutEn));
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        totalChecks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic endOfTest();
        $display("checks %0d mismatches %0d", totalChecks, mismatches);
        if (mismatches == 0 && totalChecks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : endOfTest
    task automatic header(input logic [7:0] op, input logic [10:0] pg, input logic [8:0] ba);
        logic [31:0] h;
        h = {op, 4'h0, pg, ba};
        host.open_frame();
        for (int i = 3; i >= 0; i--)
            host.send_byte(h[8*i+:8], 1'b0);
    endtask : header
    task automatic status_rd(input logic [7:0] op, input logic rdy);
        expQ.push_back({8'h80, rdy, 7'h0});
        host.open_frame();
        host.send_byte(op, 1'b0);
        host.send_byte(8'h00, 1'b1);
        host.close_frame();
    endtask : status_rd
    always @(host.rxDone) begin
        logic [15:0] e;
        e = expQ.pop_front();
        check("readByte", {24'h0, e[7:0]}, {24'h0, host.rxByte & e[15:8]});
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            endOfTest();
        end
    end
    initial begin
        logic [7:0] d[3];
        logic [10:0] pg;
        int t0;
        repeat (3) @(posedge core_clk);
        #1 rst_b = 1'b1;
        check("reset", {1'b1, 1'b0, 8'h0, 11'h0}, {readyB, serOutEn, lastOpcode, pageAddr});
        host.wait_cyc(3);
        for (int b = 0; b < 2; b++) begin
            host.cpol = b[0];
            for (int i = 0; i < 3; i++)
                d[i] = 8'($random(seed));
            header(b ? `OP_BUF2_WR : `OP_BUF1_WR, 11'h0, 9'd262);
            for (int i = 0; i < 3; i++)
                host.send_byte(d[i], 1'b0);
            host.close_frame();
            host.cpol = ~b[0];
            header(b ? `OP_BUF2_RD_LEGACY : `OP_BUF1_RD, 11'h0, 9'd262);
            for (int i = 0; i < 3; i++) begin
                expQ.push_back({8'hff, d[i]});
                host.send_byte(8'h00, 1'b1);
            end
            host.close_frame();
        end
        $display("test buffers done");
        foreach (rdTab[i]) begin
            pg = 11'($random(seed));
            host.cpol = i[0];
            host.sawEn = 1'b0;
            header(rdTab[i], pg, 9'h0);
            host.send_byte(8'h00, 1'b0);
            host.close_frame();
            check("opcode", {24'h0, rdTab[i]}, {24'h0, lastOpcode});
            check("page", {21'h0, pg}, {21'h0, pageAddr});
            check("outEn", 32'h0, {31'h0, host.sawEn});
        end
        status_rd(`OP_STAT_RD, 1'b1);
        status_rd(`OP_STAT_RD_LEGACY, 1'b1);
        $display("test reads done");
        foreach (opTab[i]) begin
            pg = 11'($random(seed));
            host.cpol = i[0];
            header(opTab[i], pg, 9'h0);
            t0 = cycles + 14;
            host.close_frame();
            check("opcode", {24'h0, opTab[i]}, {24'h0, lastOpcode});
            check("busy", 32'h0, {31'h0, readyB});
            status_rd(i[0] ? `OP_STAT_RD_LEGACY : `OP_STAT_RD, 1'b0);
            while (readyB !== 1'b1 && cycles < t0 + lenTab[i] + 40)
                @(posedge core_clk);
            check("busyTime", 32'h1, {31'h0, (cycles - t0 <= lenTab[i] + 12) && (cycles - t0 + 12 >= lenTab[i])});
        end
        $display("test timed ops done");
        check("queueLeft", 32'h0, expQ.size());
        endOfTest();
    end
endmodule : serial_flash_command_port_test
